// ### uabl_defs.svh
`ifndef UABL_DEFS_SVH
`define UABL_DEFS_SVH

// register byte offsets
`define UABL_OFS_MODE 8'h00
`define UABL_OFS_STATUS 8'h04
`define UABL_OFS_DIVISOR 8'h08
`define UABL_OFS_TXDATA 8'h0c
`define UABL_OFS_RXDATA 8'h10
`define UABL_OFS_IRQ_STATUS 8'h14
`define UABL_OFS_IRQ_MASK 8'h18

// mode register fields
`define UABL_MODE_HS 3
`define UABL_MODE_BREAK 4
`define UABL_MODE_AUTOBAUD 5

// status register fields
`define UABL_STA_RXDA 0
`define UABL_STA_TXFULL 1
`define UABL_STA_TXBUSY 2
`define UABL_STA_ABACT 3

// interrupt status and mask fields
`define UABL_IRQ_RX 0
`define UABL_IRQ_TXEMPTY 1
`define UABL_IRQ_ABDONE 2
`define UABL_IRQ_OVERRUN 3
`define UABL_IRQ_FRAME 4
`define UABL_IRQ_W 5

// reset values
`define UABL_DIVISOR_RST 16'h0000
`define UABL_MASK_RST 5'h00

// bit timing: oversample ticks (last phase index), then last data and break bit index
`define UABL_OVS_LO 4'hf
`define UABL_OVS_HI 4'h3
`define UABL_MID_LO 4'h7
`define UABL_MID_HI 4'h1
`define UABL_DATA_LAST 4'h7
`define UABL_BRK_LAST 4'hb

// sync measurement: fifth falling edge of 0x55 lies eight bits after start
`define UABL_SYNC_LAST_FALL 3'h3
`define UABL_RND_LO 24'h000040
`define UABL_RND_HI 24'h000010
`define UABL_SHIFT_LO 7
`define UABL_SHIFT_HI 5

// axi responses
`define UABL_RESP_OKAY 2'b00
`define UABL_RESP_SLVERR 2'b10

`endif

// ### uabl_pkg.sv
package uabl_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
  } uabl_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11, TX_STOP = 2'b10
  } uabl_tx_state_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'b00, AB_WAIT = 2'b01, AB_MEAS = 2'b11, AB_STOP = 2'b10
  } uabl_ab_state_t;

  typedef enum logic [2:0] {
    UABL_R_NONE, UABL_R_MODE, UABL_R_STATUS, UABL_R_DIVISOR,
    UABL_R_TXDATA, UABL_R_RXDATA, UABL_R_ISTAT, UABL_R_IMASK
  } uabl_reg_t;

  typedef struct packed {
    logic autobaud_enable;
    logic break_request;
    logic high_speed_baud_select;
  } uabl_mode_t;

  typedef struct packed {
    logic frame_err;
    logic [7:0] data;
  } uabl_rx_word_t;

  typedef struct packed {
    logic is_break;
    logic [7:0] data;
  } uabl_tx_word_t;

endpackage

// ### uabl_remote.sv
module uabl_remote (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 64;
  logic [8:0] got [$];
  logic [9:0] f;
  initial rxd = 1'b1;

  // one 8n1 frame, lsb first, p clock cycles a bit
  task automatic send(input int p, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (p) @(posedge aclk);
    end
  endtask

  // low stop bit means a break; hold off until the line recovers
  initial begin
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
        f[i] = txd;
        if (i < 9) repeat (bit_cyc) @(posedge aclk);
      end
      got.push_back({!f[9], f[8:1]});
      if (!f[9]) wait (txd);
    end
  end
endmodule

// ### uabl_rx.sv
module uabl_rx import uabl_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line,
  input wire logic os_tick,
  input wire logic enable,
  input wire logic [3:0] ovs_last,
  input wire logic [3:0] mid,
  output logic word_valid,
  output uabl_rx_word_t word
);

  uabl_rx_state_t state;
  logic [3:0] ph;
  logic [2:0] bitn;
  logic [7:0] shift;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RX_IDLE;
      ph <= 4'h0;
      bitn <= 3'h0;
      shift <= 8'h00;
      word_valid <= 1'b0;
      word <= '0;
    end else begin
      word_valid <= 1'b0;
      if (!enable) begin
        state <= RX_IDLE;
      end else begin
        case (state)
          RX_IDLE: begin
            if (!line) begin
              state <= RX_START;
              ph <= 4'h0;
            end
          end
          RX_START: begin
            if (os_tick) begin
              if (ph == mid) begin
                // a start bit gone high by mid-bit is a glitch
                ph <= 4'h0;
                bitn <= 3'h0;
                state <= line ? RX_IDLE : RX_DATA;
              end else begin
                ph <= ph + 4'h1;
              end
            end
          end
          RX_DATA: begin
            if (os_tick) begin
              if (ph == ovs_last) begin
                ph <= 4'h0;
                shift <= {line, shift[7:1]};
                if (bitn == 3'h7) begin
                  state <= RX_STOP;
                end else begin
                  bitn <= bitn + 3'h1;
                end
              end else begin
                ph <= ph + 4'h1;
              end
            end
          end
          RX_STOP: begin
            if (os_tick) begin
              if (ph == ovs_last) begin
                word_valid <= 1'b1;
                word.data <= shift;
                word.frame_err <= ~line;
                state <= RX_IDLE;
              end else begin
                ph <= ph + 4'h1;
              end
            end
          end
          default: begin
            state <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### uabl_top.sv
// Summary of operation
// - mode bit 3 selects high-speed 4x sampling; reception works for every divisor.
// - with high speed set, auto-baud derives the divisor from the 4x relation.
// - status bit 0 shows received data is waiting; qualifies overrun interrupts.
// - auto-baud measures the 0x55 sync character and never stores it as data.
// - auto-baud starts when software writes one to its enable bit.
// - auto-baud divisor is rounded to the nearest value, never off by one.
// - each dummy write with break requested sends a break, even back to back.
// - auto-baud raises the receive interrupt once, after the sync character only.
`include "uabl_defs.svh"

module uabl_top import uabl_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd,
  output logic irq
);

  function automatic uabl_reg_t uabl_decode(input logic [7:0] a);
    case (a)
      `UABL_OFS_MODE: uabl_decode = UABL_R_MODE;
      `UABL_OFS_STATUS: uabl_decode = UABL_R_STATUS;
      `UABL_OFS_DIVISOR: uabl_decode = UABL_R_DIVISOR;
      `UABL_OFS_TXDATA: uabl_decode = UABL_R_TXDATA;
      `UABL_OFS_RXDATA: uabl_decode = UABL_R_RXDATA;
      `UABL_OFS_IRQ_STATUS: uabl_decode = UABL_R_ISTAT;
      `UABL_OFS_IRQ_MASK: uabl_decode = UABL_R_IMASK;
      default: uabl_decode = UABL_R_NONE;
    endcase
  endfunction

  // bus slave state
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  uabl_reg_t wsel;
  uabl_reg_t rsel;
  logic [31:0] rd_word;
  logic do_write;
  logic wr_mode;
  logic wr_div;
  logic wr_txdata;
  logic wr_istat;
  logic wr_imask;
  logic rx_pop;

  // registers
  uabl_mode_t mode;
  logic [15:0] divisor;
  logic [`UABL_IRQ_W-1:0] irq_status;
  logic [`UABL_IRQ_W-1:0] irq_mask;
  logic [`UABL_IRQ_W-1:0] next_irq_status;
  logic [`UABL_IRQ_W-1:0] irq_event;
  logic [`UABL_IRQ_W-1:0] irq_clear;

  // baud timing
  logic [15:0] bd_cnt;
  logic os_tick;
  logic [3:0] ovs_last;
  logic [3:0] mid;

  // receive side
  logic rx_meta;
  logic rx_s;
  logic rx_q;
  logic fall;
  logic rise;
  logic rx_enable;
  logic rx_valid;
  uabl_rx_word_t rx_word;
  uabl_rx_word_t rx_buf;
  logic rx_avail;

  // transmit side
  uabl_tx_word_t hold;
  logic hold_full;
  logic tx_take;
  logic tx_load;
  uabl_tx_state_t tx_state;
  logic [3:0] tx_ph;
  logic [3:0] tx_bitn;
  logic [7:0] tx_shift;
  logic tx_brk;

  // auto-baud
  uabl_ab_state_t ab_state;
  logic [23:0] ab_cnt;
  logic [2:0] ab_falls;
  logic ab_done;
  logic [23:0] ab_round;
  logic [23:0] ab_units;
  logic [15:0] ab_div;

  assign wsel = uabl_decode(aw_addr);
  assign rsel = uabl_decode(araddr);
  assign do_write = aw_hold & w_hold & ~bvalid;
  assign wr_mode = do_write & (wsel == UABL_R_MODE) & w_strb[0];
  assign wr_div = do_write & (wsel == UABL_R_DIVISOR);
  assign wr_txdata = do_write & (wsel == UABL_R_TXDATA) & w_strb[0];
  assign wr_istat = do_write & (wsel == UABL_R_ISTAT) & w_strb[0];
  assign wr_imask = do_write & (wsel == UABL_R_IMASK) & w_strb[0];
  assign rx_pop = arvalid & arready & (rsel == UABL_R_RXDATA);

  // write address and write data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (bvalid && bready) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold <= 1'b1;
      wready <= 1'b0;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (bvalid && bready) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `UABL_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (wsel == UABL_R_NONE) ? `UABL_RESP_SLVERR : `UABL_RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (rsel)
      UABL_R_MODE: begin
        rd_word[`UABL_MODE_HS] = mode.high_speed_baud_select;
        rd_word[`UABL_MODE_BREAK] = mode.break_request;
        rd_word[`UABL_MODE_AUTOBAUD] = mode.autobaud_enable;
      end
      UABL_R_STATUS: begin
        rd_word[`UABL_STA_RXDA] = rx_avail;
        rd_word[`UABL_STA_TXFULL] = hold_full;
        rd_word[`UABL_STA_TXBUSY] = (tx_state != TX_IDLE);
        rd_word[`UABL_STA_ABACT] = (ab_state != AB_IDLE);
      end
      UABL_R_DIVISOR: rd_word[15:0] = divisor;
      UABL_R_RXDATA: rd_word[8:0] = rx_buf;
      UABL_R_ISTAT: rd_word[`UABL_IRQ_W-1:0] = irq_status;
      UABL_R_IMASK: rd_word[`UABL_IRQ_W-1:0] = irq_mask;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `UABL_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (rsel == UABL_R_NONE) ? `UABL_RESP_SLVERR : `UABL_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // software write wins over a same-cycle hardware clear so a re-arm is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= '0;
    end else if (wr_mode) begin
      mode.high_speed_baud_select <= w_data[`UABL_MODE_HS];
      mode.break_request <= w_data[`UABL_MODE_BREAK];
      mode.autobaud_enable <= w_data[`UABL_MODE_AUTOBAUD];
    end else begin
      if (ab_done) begin
        mode.autobaud_enable <= 1'b0;
      end
      if (tx_take) begin
        mode.break_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor <= `UABL_DIVISOR_RST;
    end else if (wr_div) begin
      if (w_strb[0]) begin
        divisor[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        divisor[15:8] <= w_data[15:8];
      end
    end else if (ab_done) begin
      divisor <= ab_div;
    end
  end

  // one tick every divisor+1 cycles; counting up means a new divisor
  // (software or auto-baud) takes hold at once, not after a stale 0xffff count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bd_cnt <= 16'h0000;
      os_tick <= 1'b0;
    end else if (bd_cnt >= divisor) begin
      bd_cnt <= 16'h0000;
      os_tick <= 1'b1;
    end else begin
      bd_cnt <= bd_cnt + 16'h0001;
      os_tick <= 1'b0;
    end
  end

  assign ovs_last = mode.high_speed_baud_select ? `UABL_OVS_HI : `UABL_OVS_LO;
  assign mid = mode.high_speed_baud_select ? `UABL_MID_HI : `UABL_MID_LO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rx_s <= rx_meta;
      rx_q <= rx_s;
    end
  end

  assign fall = rx_q & ~rx_s;
  assign rise = ~rx_q & rx_s;

  // receiver is held off while measuring so the sync byte is never stored
  assign rx_enable = ~mode.autobaud_enable & (ab_state == AB_IDLE);

  uabl_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .line(rx_s),
    .os_tick(os_tick),
    .enable(rx_enable),
    .ovs_last(ovs_last),
    .mid(mid),
    .word_valid(rx_valid),
    .word(rx_word)
  );

  // a byte landing in the cycle of a pop keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_avail <= 1'b0;
      rx_buf <= '0;
    end else if (rx_valid) begin
      rx_avail <= 1'b1;
      rx_buf <= rx_word;
    end else if (rx_pop) begin
      rx_avail <= 1'b0;
    end
  end

  // sync measured from start edge to fifth falling edge: eight bit times
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ab_state <= AB_IDLE;
      ab_cnt <= 24'h000000;
      ab_falls <= 3'h0;
    end else if (!mode.autobaud_enable) begin
      ab_state <= AB_IDLE;
    end else begin
      case (ab_state)
        AB_IDLE: ab_state <= AB_WAIT;
        AB_WAIT: begin
          if (fall) begin
            ab_state <= AB_MEAS;
            ab_cnt <= 24'h000001;
            ab_falls <= 3'h0;
          end
        end
        AB_MEAS: begin
          if (fall && (ab_falls == `UABL_SYNC_LAST_FALL)) begin
            ab_state <= AB_STOP;
          end else begin
            if (fall) begin
              ab_falls <= ab_falls + 3'h1;
            end
            if (ab_cnt != 24'hffffff) begin
              ab_cnt <= ab_cnt + 24'h000001;
            end
          end
        end
        AB_STOP: begin
          if (rise) begin
            ab_state <= AB_IDLE;
          end
        end
        default: ab_state <= AB_IDLE;
      endcase
    end
  end

  assign ab_done = mode.autobaud_enable & (ab_state == AB_STOP) & rise;

  // round to nearest before the minus one; truncation gave the off-by-one
  always_comb begin
    if (mode.high_speed_baud_select) begin
      ab_round = ab_cnt + `UABL_RND_HI;
      ab_units = ab_round >> `UABL_SHIFT_HI;
    end else begin
      ab_round = ab_cnt + `UABL_RND_LO;
      ab_units = ab_round >> `UABL_SHIFT_LO;
    end
    if (ab_units == 24'h000000) begin
      ab_div = 16'h0000;
    end else if (ab_units > 24'h010000) begin
      ab_div = 16'hffff;
    end else begin
      ab_div = 16'(ab_units - 24'h000001);
    end
  end

  assign tx_take = wr_txdata & ~hold_full;
  assign tx_load = (tx_state == TX_IDLE) & hold_full;

  // break flag travels with its own dummy byte, so back-to-back breaks hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_full <= 1'b0;
      hold <= '0;
    end else if (tx_take) begin
      hold_full <= 1'b1;
      hold.data <= w_data[7:0];
      hold.is_break <= mode.break_request;
    end else if (tx_load) begin
      hold_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      txd <= 1'b1;
      tx_ph <= 4'h0;
      tx_bitn <= 4'h0;
      tx_shift <= 8'h00;
      tx_brk <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (hold_full) begin
            tx_state <= TX_START;
            txd <= 1'b0;
            tx_ph <= 4'h0;
            tx_shift <= hold.is_break ? 8'h00 : hold.data;
            tx_brk <= hold.is_break;
          end
        end
        TX_START: begin
          if (os_tick) begin
            if (tx_ph == ovs_last) begin
              tx_ph <= 4'h0;
              tx_bitn <= 4'h0;
              tx_state <= TX_DATA;
              txd <= tx_shift[0] & ~tx_brk;
            end else begin
              tx_ph <= tx_ph + 4'h1;
            end
          end
        end
        TX_DATA: begin
          if (os_tick) begin
            if (tx_ph == ovs_last) begin
              tx_ph <= 4'h0;
              if (tx_bitn == (tx_brk ? `UABL_BRK_LAST : `UABL_DATA_LAST)) begin
                tx_state <= TX_STOP;
                txd <= 1'b1;
              end else begin
                tx_bitn <= tx_bitn + 4'h1;
                tx_shift <= {1'b0, tx_shift[7:1]};
                txd <= tx_shift[1] & ~tx_brk;
              end
            end else begin
              tx_ph <= tx_ph + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (os_tick) begin
            if (tx_ph == ovs_last) begin
              tx_state <= TX_IDLE;
            end else begin
              tx_ph <= tx_ph + 4'h1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
          txd <= 1'b1;
        end
      endcase
    end
  end

  // sync completion is the single receive event of an auto-baud sequence
  always_comb begin
    irq_event = '0;
    irq_event[`UABL_IRQ_RX] = rx_valid | ab_done;
    irq_event[`UABL_IRQ_TXEMPTY] = tx_load;
    irq_event[`UABL_IRQ_ABDONE] = ab_done;
    irq_event[`UABL_IRQ_OVERRUN] = rx_valid & rx_avail & ~rx_pop;
    irq_event[`UABL_IRQ_FRAME] = rx_valid & rx_word.frame_err;
    irq_clear = wr_istat ? w_data[`UABL_IRQ_W-1:0] : '0;
    next_irq_status = (irq_status & ~irq_clear) | irq_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask <= `UABL_MASK_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_imask) begin
        irq_mask <= w_data[`UABL_IRQ_W-1:0];
      end
      irq <= |(next_irq_status & (wr_imask ? w_data[`UABL_IRQ_W-1:0] : irq_mask));
    end
  end

endmodule

// ### uabl_top_checker.sv
`include "uabl_defs.svh"

module uabl_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_take;
  logic rd_take;
  assign wr_take = awvalid && awready && wvalid && wready;
  assign rd_take = arvalid && arready;

  wr_resp_time_a: assert property (wr_take |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after the take");
  rd_resp_time_a: assert property (rd_take |=> rvalid)
    else $error("read data not one cycle after the take");
  wr_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channels ready while a response is pending");
  rd_busy_a: assert property (rvalid |-> !arready)
    else $error("read address ready while read data is pending");
  wr_free_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channels not freed after the response");
  rd_free_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not freed after the data");
  rd_unmapped_a: assert property (rd_take && araddr > 8'h18
    |=> rresp == `UABL_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_unmapped_a: assert property (wr_take && awaddr > 8'h18
    |=> ##1 bvalid && bresp == `UABL_RESP_SLVERR)
    else $error("unmapped write not refused");
  mode_fields_a: assert property (
    rd_take && araddr == `UABL_OFS_MODE |=> rdata[31:6] == 26'h0 && rdata[2:0] == 3'h0)
    else $error("mode read shows bits outside its fields");

  cover property (wr_take && awaddr > 8'h18);
  cover property ($rose(irq));
  cover property ($fell(txd));
endmodule

bind uabl_top uabl_top_checker chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .rxd(rxd), .txd(txd), .irq(irq));

// ### uabl_top_tb_top.sv
`include "uabl_defs.svh"

module uabl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } uabl_row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rxd;
  logic awready, wready, bvalid, arready, rvalid, txd, irq, irq_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, dat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int err_count, checked, cyc, rises, r0;
  uabl_row_t rows [0:3];
  int hsd [4] = '{0, 1, 2, 6};
  int ab_hs [4] = '{0, 1, 1, 0};
  int ab_p [4] = '{170, 40, 44, 64};
  int ab_e [4] = '{10, 9, 10, 3};
  logic [8:0] bk [3] = '{9'h177, 9'h166, 9'h05a};

  uabl_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd(rxd), .txd(txd), .irq(irq));
  uabl_remote u_remote (.aclk(aclk), .txd(txd), .rxd(rxd));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task results;
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // whole run needs well under this many cycles
  always @(posedge aclk) begin
    irq_q <= irq;
    if (irq === 1'b1 && irq_q === 1'b0) rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w && bvalid === 1'b1));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, `UABL_RESP_OKAY});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, dat, rsp);
    chk(dat, e);
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    rows[0] = {`UABL_OFS_DIVISOR, 32'h5a5aabcd, 32'h0000abcd, `UABL_RESP_OKAY};
    rows[1] = {`UABL_OFS_IRQ_MASK, 32'hffffffff, 32'h0000001f, `UABL_RESP_OKAY};
    rows[2] = {`UABL_OFS_MODE, 32'h00000008, 32'h00000008, `UABL_RESP_OKAY};
    rows[3] = {8'h1c, 32'h12345678, 32'h0, `UABL_RESP_SLVERR};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`UABL_OFS_MODE, 32'h0);
    rdc(`UABL_OFS_STATUS, 32'h0);
    rdc(`UABL_OFS_DIVISOR, 32'h0);
    rdc(`UABL_OFS_IRQ_STATUS, 32'h0);
    rdc(`UABL_OFS_IRQ_MASK, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
      rd(rows[i].a, dat, rsp);
      chk(dat, rows[i].e);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
    end
    // normal reception, irq raised, masked, cleared
    wrc(`UABL_OFS_MODE, 32'h0);
    wrc(`UABL_OFS_DIVISOR, 32'h3);
    u_remote.send(64, 8'ha5);
    chk({31'h0, irq}, 32'h1);
    rdc(`UABL_OFS_STATUS, 32'h1);
    rdc(`UABL_OFS_RXDATA, 32'ha5);
    rdc(`UABL_OFS_STATUS, 32'h0);
    wrc(`UABL_OFS_IRQ_STATUS, 32'h1);
    wrc(`UABL_OFS_IRQ_MASK, 32'h0);
    u_remote.send(64, 8'h5a);
    chk({31'h0, irq}, 32'h0);
    rdc(`UABL_OFS_IRQ_STATUS, 32'h1);
    wrc(`UABL_OFS_IRQ_MASK, 32'h1);
    rdc(`UABL_OFS_RXDATA, 32'h5a);
    chk({31'h0, irq}, 32'h1);
    wrc(`UABL_OFS_IRQ_STATUS, 32'h1f);
    // high speed reception across divisors, fastest first
    foreach (hsd[i]) begin
      wrc(`UABL_OFS_DIVISOR, 32'(hsd[i]));
      wrc(`UABL_OFS_MODE, 32'h8);
      u_remote.send(4 * (hsd[i] + 1), 8'h30 + 8'(hsd[i]));
      // high speed samples late in the stop bit: wait for the byte to land
      do rd(`UABL_OFS_STATUS, dat, rsp); while (dat[0] !== 1'b1);
      rdc(`UABL_OFS_RXDATA, 32'h30 + 32'(hsd[i]));
      wrc(`UABL_OFS_IRQ_STATUS, 32'h1f);
    end
    // auto-baud from a preloaded all-ones divisor
    foreach (ab_p[i]) begin
      wrc(`UABL_OFS_DIVISOR, 32'hffff);
      wrc(`UABL_OFS_MODE, 32'h20 | (32'(ab_hs[i]) << 3));
      r0 = rises;
      u_remote.send(ab_p[i], 8'h55);
      do rd(`UABL_OFS_MODE, dat, rsp); while (dat[5] !== 1'b0);
      chk(dat, 32'(ab_hs[i]) << 3);
      rdc(`UABL_OFS_DIVISOR, 32'(ab_e[i]));
      rdc(`UABL_OFS_STATUS, 32'h0);
      rdc(`UABL_OFS_IRQ_STATUS, 32'h5);
      chk(32'(rises - r0), 32'h1);
      wrc(`UABL_OFS_IRQ_STATUS, 32'h1f);
      u_remote.send(ab_p[i], 8'hc3);
      do rd(`UABL_OFS_STATUS, dat, rsp); while (dat[0] !== 1'b1);
      rdc(`UABL_OFS_RXDATA, 32'hc3);
      // irq must be low again before the next sync so its rise is counted
      wrc(`UABL_OFS_IRQ_STATUS, 32'h1f);
    end
    // two breaks back to back, then ordinary data
    wrc(`UABL_OFS_MODE, 32'h0);
    wrc(`UABL_OFS_DIVISOR, 32'h3);
    u_remote.bit_cyc = 64;
    foreach (bk[i]) begin
      do rd(`UABL_OFS_STATUS, dat, rsp); while (dat[1] !== 1'b0);
      if (bk[i][8]) wrc(`UABL_OFS_MODE, 32'h10);
      wrc(`UABL_OFS_TXDATA, {24'h0, bk[i][7:0]});
      rdc(`UABL_OFS_MODE, 32'h0);
    end
    while (u_remote.got.size() < 3) @(posedge aclk);
    foreach (bk[i]) chk({23'h0, u_remote.got[i]}, bk[i][8] ? 32'h100 : {24'h0, bk[i][7:0]});
    results();
  end
endmodule
